// [isf_bus_agent.sv]
// far-side bus agent: open-drain clock and data with pull-ups, frames start and stop
`timescale 1ns/1ps
`default_nettype none
module isf_bus_agent (
    // stretch request from the block
    input  wire logic scl_hold_i,
    // resolved bus lines
    output logic      scl_o,
    output logic      sda_o
);
    logic scl_low = 1'b0;
    logic sda_low = 1'b0;
    // wired-and with pull-ups: a released line reads high, a stretch keeps clock low
    assign scl_o = ~(scl_low | scl_hold_i);
    assign sda_o = ~sda_low;
    // start, then a byte plus acknowledge of clocks at 800 ns; clock idles outside frames
    task send_start;
        #400 sda_low = 1'b1;
        #400 scl_low = 1'b1;
        repeat (9) begin
            #400 scl_low = 1'b0;
            #400 scl_low = 1'b1;
        end
    endtask : send_start
    // data already low under a low clock: release clock, then data, giving a stop
    task send_stop;
        #400 scl_low = 1'b0;
        #400 sda_low = 1'b0;
        #400; // bus free time, lets the synchronised stop reach the busy flag
    endtask : send_stop
endmodule : isf_bus_agent
`default_nettype wire

// [isf_pkg.sv]
// package of offsets, field positions and reset values for the status flag block
`default_nettype none
package isf_pkg;
    // apb byte offsets of the register window
    localparam logic [7:0] OFF_CTRL   = 8'h00;
    localparam logic [7:0] OFF_STAT1  = 8'h04;
    localparam logic [7:0] OFF_STAT2  = 8'h08;
    localparam logic [7:0] OFF_DATA   = 8'h0c;
    localparam logic [7:0] OFF_OWNADR = 8'h10;
    // control register fields
    localparam int CTRL_ITE   = 0;
    localparam int CTRL_START = 3;
    localparam int CTRL_ACK   = 2;
    localparam int CTRL_PE    = 5;
    // first status register fields
    localparam int ST1_EVF    = 7;
    localparam int ST1_HEADER_SENT_FLAG  = 6;
    localparam int ST1_TRA    = 5;
    localparam int ST1_BUSY   = 4;
    localparam int ST1_BTF    = 3;
    localparam int ST1_ADDRESS_MATCHED_FLAG   = 2;
    localparam int ST1_MSL    = 1;
    localparam int ST1_SB     = 0;
    // second status register fields
    localparam int ST2_NACK   = 4;
    localparam int ST2_SLAVE_STOP_SEEN_FLAG  = 3;
    localparam int ST2_ARBITRATION_LOST_FLAG   = 2;
    localparam int ST2_BUS_ERROR_FLAG   = 1;
    localparam int ST2_GCALL  = 0;
    // reset values
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [7:0] DATA_RST   = 8'h00;
    localparam logic [7:0] OWNADR_RST = 8'h00;
    // pin synchroniser depth
    localparam int SYNC_STAGES = 2;
endpackage : isf_pkg
`default_nettype wire

// [isf_status_flags.sv]
// status flag logic of a multimaster two-wire interface with an apb register port
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module isf_status_flags (
    // clock and reset
    input  wire logic        clock_i,
    input  wire logic        reset_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // two-wire bus pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             scl_o,
    output logic             scl_oe_o,
    // events from the shift engine, same clock
    input  wire logic        tx_ninth_pulse_i,
    input  wire logic        rx_ack_pulse_i,
    input  wire logic [7:0]  rx_byte_i,
    input  wire logic        addr_byte_sent_i,
    input  wire logic        header_sent_i,
    input  wire logic        slave_addr_valid_i,
    input  wire logic [7:0]  slave_addr_i,
    input  wire logic        start_sent_i,
    input  wire logic        no_ack_i,
    input  wire logic        slave_stop_i,
    input  wire logic        arb_lost_i,
    input  wire logic        bus_error_i,
    // controls towards the shift engine
    output logic             peripheral_enable_o,
    output logic             ack_enable_o,
    output logic             start_request_o,
    output logic [7:0]       tx_byte_o,
    output logic             irq_o
);
    // apb decode
    logic        access;
    logic        wr_ctrl;
    logic        wr_data;
    logic        rd_stat1;
    logic        rd_stat2;
    logic        rd_data;
    logic        mapped;

    // register state
    logic [7:0]  ctrl_q, ctrl_d;
    logic [7:0]  tx_q, tx_d;
    logic [7:0]  rx_q, rx_d;
    logic [7:0]  own_q, own_d;
    logic [31:0] rdata_q, rdata_d;
    logic        err_q, err_d;

    // flag state
    logic        btf_q, btf_d;
    logic        btf_pend_q, btf_pend_d;
    logic        tra_q, tra_d;
    logic        address_matched_flag_q, address_matched_flag_d;
    logic        header_sent_flag_q, header_sent_flag_d;
    logic        sb_q, sb_d;
    logic        msl_q, msl_d;
    logic        busy_q, busy_d;
    logic        ev6_q, ev6_d;
    logic        nack_q, nack_d;
    logic        slave_stop_seen_flag_q, slave_stop_seen_flag_d;
    logic        arbitration_lost_flag_q, arbitration_lost_flag_d;
    logic        bus_error_flag_q, bus_error_flag_d;
    logic        gcall_q, gcall_d;
    logic        armed1_q, armed1_d;
    logic        armed2_q, armed2_d;

    // pin synchronisers and edge history
    logic [isf_pkg::SYNC_STAGES-1:0] scl_sync_q;
    logic [isf_pkg::SYNC_STAGES-1:0] sda_sync_q;
    logic        scl_prev_q;
    logic        sda_prev_q;
    logic        scl_s;
    logic        sda_s;
    logic        start_seen;
    logic        stop_seen;

    logic        pe;
    logic        event_summary_flag;
    logic        addr_match;
    logic        gcall_match;
    logic [7:0]  stat1;
    logic [7:0]  stat2;

    // apb access decode, slave answers in the access cycle
    assign access   = psel_i & penable_i;
    assign mapped   = (paddr_i == isf_pkg::OFF_CTRL)  | (paddr_i == isf_pkg::OFF_STAT1) |
                      (paddr_i == isf_pkg::OFF_STAT2) | (paddr_i == isf_pkg::OFF_DATA)  |
                      (paddr_i == isf_pkg::OFF_OWNADR);
    assign wr_ctrl  = access & pwrite_i & (paddr_i == isf_pkg::OFF_CTRL);
    assign wr_data  = access & pwrite_i & (paddr_i == isf_pkg::OFF_DATA);
    assign rd_stat1 = access & ~pwrite_i & (paddr_i == isf_pkg::OFF_STAT1);
    assign rd_stat2 = access & ~pwrite_i & (paddr_i == isf_pkg::OFF_STAT2);
    assign rd_data  = access & ~pwrite_i & (paddr_i == isf_pkg::OFF_DATA);
    assign pready_o = 1'b1;

    // synchronised pin levels and start or stop detection
    assign scl_s      = scl_sync_q[isf_pkg::SYNC_STAGES-1];
    assign sda_s      = sda_sync_q[isf_pkg::SYNC_STAGES-1];
    assign start_seen = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
    assign stop_seen  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

    // address comparison for the slave side
    assign gcall_match = ctrl_q[isf_pkg::CTRL_ACK] & (slave_addr_i == 8'h00);
    assign addr_match  = slave_addr_valid_i &
                         ((slave_addr_i[7:1] == own_q[7:1]) | gcall_match);

    // status words as software sees them
    assign pe  = ctrl_q[isf_pkg::CTRL_PE];
    assign event_summary_flag = pe & (btf_q | address_matched_flag_q | sb_q | nack_q | slave_stop_seen_flag_q | arbitration_lost_flag_q | bus_error_flag_q |
                       header_sent_flag_q | ev6_q);
    always_comb begin
        stat1 = 8'h00;
        stat1[isf_pkg::ST1_EVF]   = event_summary_flag;
        stat1[isf_pkg::ST1_HEADER_SENT_FLAG] = header_sent_flag_q;
        stat1[isf_pkg::ST1_TRA]   = tra_q;
        stat1[isf_pkg::ST1_BUSY]  = busy_q;
        stat1[isf_pkg::ST1_BTF]   = btf_q;
        stat1[isf_pkg::ST1_ADDRESS_MATCHED_FLAG]  = address_matched_flag_q;
        stat1[isf_pkg::ST1_MSL]   = msl_q;
        stat1[isf_pkg::ST1_SB]    = sb_q;
        stat2 = 8'h00;
        stat2[isf_pkg::ST2_NACK]  = nack_q;
        stat2[isf_pkg::ST2_SLAVE_STOP_SEEN_FLAG] = slave_stop_seen_flag_q;
        stat2[isf_pkg::ST2_ARBITRATION_LOST_FLAG]  = arbitration_lost_flag_q;
        stat2[isf_pkg::ST2_BUS_ERROR_FLAG]  = bus_error_flag_q;
        stat2[isf_pkg::ST2_GCALL] = gcall_q;
    end

    // register file next state and read mux
    always_comb begin
        ctrl_d  = ctrl_q;
        tx_d    = tx_q;
        rx_d    = rx_q;
        own_d   = own_q;
        rdata_d = rdata_q;
        err_d   = 1'b0;
        if (wr_ctrl) begin
            ctrl_d = pwdata_i[7:0] & 8'h3d;
        end
        if (wr_data) begin
            tx_d = pwdata_i[7:0];
        end
        if (access & pwrite_i & (paddr_i == isf_pkg::OFF_OWNADR)) begin
            own_d = pwdata_i[7:0];
        end
        if (rx_ack_pulse_i) begin
            rx_d = rx_byte_i;
        end
        if (start_sent_i) begin
            ctrl_d[isf_pkg::CTRL_START] = 1'b0;
        end
        if (!ctrl_d[isf_pkg::CTRL_PE]) begin
            ctrl_d = ctrl_d & 8'h02; // disable drops all control bits except bit 1
        end
        if (psel_i & ~penable_i & ~pwrite_i) begin
            case (paddr_i)
                isf_pkg::OFF_CTRL:   rdata_d = {24'h000000, ctrl_q};
                isf_pkg::OFF_STAT1:  rdata_d = {24'h000000, stat1};
                isf_pkg::OFF_STAT2:  rdata_d = {24'h000000, stat2};
                isf_pkg::OFF_DATA:   rdata_d = {24'h000000, rx_q};
                isf_pkg::OFF_OWNADR: rdata_d = {24'h000000, own_q};
                default:             rdata_d = 32'h00000000;
            endcase
        end
        if (psel_i & ~penable_i) begin
            err_d = ~mapped;
        end
    end

    // register file storage, status words accept no writes
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            ctrl_q  <= isf_pkg::CTRL_RST;
            tx_q    <= isf_pkg::DATA_RST;
            rx_q    <= isf_pkg::DATA_RST;
            own_q   <= isf_pkg::OWNADR_RST;
            rdata_q <= 32'h00000000;
            err_q   <= 1'b0;
        end else begin
            ctrl_q  <= ctrl_d;
            tx_q    <= tx_d;
            rx_q    <= rx_d;
            own_q   <= own_d;
            rdata_q <= rdata_d;
            err_q   <= err_d;
        end
    end

    // pin synchronisers, second stage feeds the edge history
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_sync_q <= '1;
            sda_sync_q <= '1;
            scl_prev_q <= 1'b1;
            sda_prev_q <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[isf_pkg::SYNC_STAGES-2:0], scl_i};
            sda_sync_q <= {sda_sync_q[isf_pkg::SYNC_STAGES-2:0], sda_i};
            scl_prev_q <= scl_s;
            sda_prev_q <= sda_s;
        end
    end

    // flag next state: a set in the clearing cycle wins, except busy, where a bus error beats a start
    always_comb begin
        armed1_d   = armed1_q;
        armed2_d   = armed2_q;
        if (rd_stat1) begin
            armed1_d = 1'b1;
        end else if (wr_data | rd_data | wr_ctrl) begin
            armed1_d = 1'b0;
        end
        if (rd_stat2) begin
            armed2_d = 1'b1;
        end else if (wr_data) begin
            armed2_d = 1'b0;
        end
        // address phase done, cleared by status1 read then control write
        ev6_d = addr_byte_sent_i | (ev6_q & ~(armed1_q & wr_ctrl));
        // transmit finish is held back while the address phase is pending
        btf_pend_d = (btf_pend_q | tx_ninth_pulse_i) & ev6_d;
        btf_d = ((tx_ninth_pulse_i | btf_pend_q) & ~ev6_d) |
                (rx_ack_pulse_i & ctrl_q[isf_pkg::CTRL_ACK]) |
                (btf_q & ~(armed1_q & (wr_data | rd_data)));
        if ((tx_ninth_pulse_i | btf_pend_q) & ~ev6_d) begin
            tra_d = 1'b1;
        end else if (rx_ack_pulse_i & ctrl_q[isf_pkg::CTRL_ACK]) begin
            tra_d = 1'b0;
        end else begin
            tra_d = tra_q & btf_d & ~stop_seen & ~slave_stop_i & ~arb_lost_i;
        end
        address_matched_flag_d  = addr_match | (address_matched_flag_q & ~rd_stat1);
        gcall_d = (addr_match & gcall_match) | (gcall_q & ~rd_stat2);
        header_sent_flag_d = header_sent_i | (header_sent_flag_q & ~(armed2_q & wr_data));
        sb_d    = start_sent_i | (sb_q & ~(armed1_q & wr_data));
        msl_d   = (wr_ctrl & pwdata_i[isf_pkg::CTRL_START]) |
                  (msl_q & ~stop_seen & ~arb_lost_i);
        nack_d  = no_ack_i | (nack_q & ~rd_stat2);
        slave_stop_seen_flag_d = slave_stop_i | (slave_stop_seen_flag_q & ~rd_stat2);
        arbitration_lost_flag_d  = arb_lost_i | (arbitration_lost_flag_q & ~rd_stat2);
        bus_error_flag_d  = bus_error_i | (bus_error_flag_q & ~rd_stat2);
        // bus busy tracks the line only while enabled
        busy_d = busy_q;
        if (pe) begin
            if (bus_error_i) begin
                busy_d = 1'b0;
            end else if (start_seen) begin
                busy_d = 1'b1;
            end else if (stop_seen) begin
                busy_d = 1'b0;
            end
        end
        // disabled interface drops every flag but busy
        if (!ctrl_d[isf_pkg::CTRL_PE]) begin
            ev6_d      = 1'b0;
            btf_pend_d = 1'b0;
            btf_d      = 1'b0;
            tra_d      = 1'b0;
            address_matched_flag_d     = 1'b0;
            gcall_d    = 1'b0;
            header_sent_flag_d    = 1'b0;
            sb_d       = 1'b0;
            msl_d      = 1'b0;
            nack_d     = 1'b0;
            slave_stop_seen_flag_d    = 1'b0;
            arbitration_lost_flag_d     = 1'b0;
            bus_error_flag_d     = 1'b0;
            armed1_d   = 1'b0;
            armed2_d   = 1'b0;
        end
    end

    // flag storage
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            btf_q      <= 1'b0;
            btf_pend_q <= 1'b0;
            tra_q      <= 1'b0;
            address_matched_flag_q     <= 1'b0;
            header_sent_flag_q    <= 1'b0;
            sb_q       <= 1'b0;
            msl_q      <= 1'b0;
            busy_q     <= 1'b0;
            ev6_q      <= 1'b0;
            nack_q     <= 1'b0;
            slave_stop_seen_flag_q    <= 1'b0;
            arbitration_lost_flag_q     <= 1'b0;
            bus_error_flag_q     <= 1'b0;
            gcall_q    <= 1'b0;
            armed1_q   <= 1'b0;
            armed2_q   <= 1'b0;
        end else begin
            btf_q      <= btf_d;
            btf_pend_q <= btf_pend_d;
            tra_q      <= tra_d;
            address_matched_flag_q     <= address_matched_flag_d;
            header_sent_flag_q    <= header_sent_flag_d;
            sb_q       <= sb_d;
            msl_q      <= msl_d;
            busy_q     <= busy_d;
            ev6_q      <= ev6_d;
            nack_q     <= nack_d;
            slave_stop_seen_flag_q    <= slave_stop_seen_flag_d;
            arbitration_lost_flag_q     <= arbitration_lost_flag_d;
            bus_error_flag_q     <= bus_error_flag_d;
            gcall_q    <= gcall_d;
            armed1_q   <= armed1_d;
            armed2_q   <= armed2_d;
        end
    end

    // outputs: clock stretching, controls and interrupt
    assign scl_o               = 1'b0;
    assign scl_oe_o            = pe & (btf_q | address_matched_flag_q | sb_q | header_sent_flag_q | ev6_q);
    assign prdata_o            = rdata_q;
    assign pslverr_o           = err_q & access;
    assign peripheral_enable_o = pe;
    assign ack_enable_o        = ctrl_q[isf_pkg::CTRL_ACK];
    assign start_request_o     = ctrl_q[isf_pkg::CTRL_START];
    assign tx_byte_o           = tx_q;
    assign irq_o               = ctrl_q[isf_pkg::CTRL_ITE] & event_summary_flag;

    // checks on the flag behaviour
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    property p_evf_sum;
        btf_q |-> stat1[isf_pkg::ST1_EVF];
    endproperty
    a_evf_sum: assert property (p_evf_sum) else $error("summary flag missing");

    property p_disable;
        !ctrl_q[isf_pkg::CTRL_PE] |-> (stat1 & 8'hee) == 8'h00;
    endproperty
    a_disable: assert property (p_disable) else $error("flag set while disabled");

    property p_header;
        pe && header_sent_i |=> header_sent_flag_q;
    endproperty
    a_header: assert property (p_header) else $error("header flag not set");

    property p_header_clr;
        armed2_q && wr_data && !header_sent_i && header_sent_flag_q |=> !header_sent_flag_q;
    endproperty
    a_header_clr: assert property (p_header_clr) else $error("header flag not cleared");

    property p_tra;
        tra_q |-> btf_q;
    endproperty
    a_tra: assert property (p_tra) else $error("direction without finish");

    property p_busy_frozen;
        !pe |=> busy_q == $past(busy_q);
    endproperty
    a_busy_frozen: assert property (p_busy_frozen) else $error("busy moved");

    property p_bus_error_flag_busy;
        pe && bus_error_i |=> !busy_q;
    endproperty
    a_bus_error_flag_busy: assert property (p_bus_error_flag_busy) else $error("busy kept on error");

    property p_rx_done;
        pe && rx_ack_pulse_i && ctrl_q[isf_pkg::CTRL_ACK] |=> btf_q && !tra_q;
    endproperty
    a_rx_done: assert property (p_rx_done) else $error("receive finish missing");

    property p_ev6_block;
        ev6_q |-> !$rose(btf_q) || !$past(tx_ninth_pulse_i) || $past(rx_ack_pulse_i);
    endproperty
    a_ev6_block: assert property (p_ev6_block) else $error("finish during addr");

    property p_stretch;
        pe && (btf_q || address_matched_flag_q) |-> scl_oe_o && !scl_o;
    endproperty
    a_stretch: assert property (p_stretch) else $error("clock not held");

    property p_address_matched_flag_clr;
        rd_stat1 && !addr_match |=> !address_matched_flag_q;
    endproperty
    a_address_matched_flag_clr: assert property (p_address_matched_flag_clr) else $error("match flag kept");
endmodule : isf_status_flags
`default_nettype wire

// [tb.sv]
// self-checking bench for the status flag block with apb master and bus agent
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam logic [7:0] A_CTL = isf_pkg::OFF_CTRL;
    localparam logic [7:0] A_ST1 = isf_pkg::OFF_STAT1;
    localparam logic [7:0] A_ST2 = isf_pkg::OFF_STAT2;
    localparam logic [7:0] A_DAT = isf_pkg::OFF_DATA;
    localparam logic [7:0] A_OWN = isf_pkg::OFF_OWNADR;
    logic        clock_i, reset_n_i, psel, penable, pwrite, pready, pslverr;
    logic        scl_line, sda_line, scl_oe, pe_out, ack_out, irq, rd_err, start_req;
    logic [7:0]  paddr, tx_byte, rx_byte, s_addr;
    logic [31:0] pwdata, prdata, rd_data;
    logic [9:0]  ev;
    int          num_errors = 0;
    int          cmp_count = 0;
    int          cyc = 0;

    // block under test, shift engine events driven from ev
    isf_status_flags dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .scl_i(scl_line), .sda_i(sda_line),
        .scl_o(), .scl_oe_o(scl_oe), .tx_ninth_pulse_i(ev[0]), .rx_ack_pulse_i(ev[1]),
        .rx_byte_i(rx_byte), .addr_byte_sent_i(ev[2]), .header_sent_i(ev[3]),
        .slave_addr_valid_i(ev[4]), .slave_addr_i(s_addr), .start_sent_i(ev[5]),
        .no_ack_i(ev[6]), .slave_stop_i(ev[7]), .arb_lost_i(ev[8]), .bus_error_i(ev[9]),
        .peripheral_enable_o(pe_out), .ack_enable_o(ack_out), .start_request_o(start_req),
        .tx_byte_o(tx_byte), .irq_o(irq)
    );
    // far side of the bus
    isf_bus_agent bus (.scl_hold_i(scl_oe), .scl_o(scl_line), .sda_o(sda_line));

    // 10 MHz clock
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    // hang guard
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 20000) begin
            num_errors++;
            complete_run;
        end
    end

    task complete_run;
        $display("errors %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : complete_run

    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task bitchk(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : bitchk

    // one apb transfer: setup, access held until pready is seen high
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock_i);
        penable <= 1'b1;
        @(posedge clock_i);
        while (pready !== 1'b1) @(posedge clock_i);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(negedge clock_i); // later checks see outputs settled after the access edge
    endtask : apb

    task rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd_data, exp);
    endtask : rd

    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    // one-cycle event pulse on line b
    task pulse(input int b);
        @(posedge clock_i);
        ev <= 10'(1 << b);
        @(posedge clock_i);
        ev <= 10'h000;
        @(negedge clock_i); // flags settled before any check
    endtask : pulse

    // first write only sets enable, second sets the other bits
    task enable(input logic [31:0] v);
        wr(A_CTL, 32'h20);
        wr(A_CTL, v);
        bitchk(pe_out, 1'b1);
    endtask : enable

    task t_regs;
        rd(A_ST1, 32'h0);
        wr(A_ST1, 32'hff);
        rd(A_ST1, 32'h0);
        rd(8'h14, 32'h0);
        bitchk(rd_err, 1'b1);
    endtask : t_regs

    task t_tx;
        enable(32'h25);
        bitchk(ack_out, 1'b1);
        pulse(0);
        rd(A_ST1, 32'ha8);
        bitchk(scl_oe, 1'b1);
        bitchk(scl_line, 1'b0);
        bitchk(irq, 1'b1);
        wr(A_DAT, 32'h3c);
        chk({24'h0, tx_byte}, 32'h3c);
        rd(A_ST1, 32'h0);
        bitchk(scl_oe, 1'b0);
    endtask : t_tx

    task t_rx;
        rx_byte <= 8'h5a;
        pulse(1);
        rd(A_ST1, 32'h88);
        rd(A_DAT, 32'h5a);
        rd(A_ST1, 32'h0);
    endtask : t_rx

    task t_match;
        wr(A_OWN, 32'h42);
        s_addr <= 8'h43;
        pulse(4);
        bitchk(scl_oe, 1'b1);
        rd(A_ST1, 32'h84);
        rd(A_ST1, 32'h0);
        s_addr <= 8'h44;
        pulse(4);
        rd(A_ST1, 32'h0);
        s_addr <= 8'h00;
        pulse(4);
        rd(A_ST1, 32'h84);
        rd(A_ST1, 32'h0);
        rd(A_ST2, 32'h1);
    endtask : t_match

    task t_header;
        pulse(3);
        rd(A_ST1, 32'hc0);
        rd(A_ST2, 32'h0);
        wr(A_DAT, 32'hf0);
        rd(A_ST1, 32'h0);
        wr(A_CTL, 32'h2d);
        bitchk(start_req, 1'b1);
        pulse(5);
        bitchk(start_req, 1'b0);
        rd(A_ST1, 32'h83);
        wr(A_DAT, 32'ha0);
        rd(A_ST1, 32'h02);
        pulse(8);
        rd(A_ST1, 32'h80);
        rd(A_ST2, 32'h4);
    endtask : t_header

    // each error event alone, then cleared by the second status read
    task t_errors;
        for (int i = 6; i < 10; i++) begin
            pulse(i);
            rd(A_ST1, 32'h80);
            rd(A_ST2, 32'(1 << (10 - i)));
            rd(A_ST1, 32'h0);
        end
    endtask : t_errors

    task t_addr_phase;
        pulse(2);
        rd(A_ST1, 32'h80);
        pulse(0);
        rd(A_ST1, 32'h80);
        wr(A_CTL, 32'h25);
        rd(A_ST1, 32'ha8);
        wr(A_DAT, 32'h11);
        rd(A_ST1, 32'h0);
    endtask : t_addr_phase

    task t_disable;
        pulse(0);
        pulse(3);
        rd(A_ST1, 32'he8);
        wr(A_CTL, 32'h0);
        rd(A_ST1, 32'h0);
        bitchk(irq, 1'b0);
    endtask : t_disable

    task t_busy;
        enable(32'h25);
        bus.send_start;
        rd(A_ST1, 32'h10);
        wr(A_CTL, 32'h0);
        bus.send_stop;
        rd(A_ST1, 32'h10);
        // bus goes idle while disabled so the stop is missed, stale busy is then cleared by an error
        enable(32'h25);
        pulse(9);
        rd(A_ST1, 32'h80);
        rd(A_ST2, 32'h2);
        bus.send_start;
        rd(A_ST1, 32'h10);
        bus.send_stop;
        rd(A_ST1, 32'h0);
    endtask : t_busy

    // reset, then the scenarios in turn
    initial begin
        reset_n_i = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        ev = 10'h000;
        rx_byte = 8'h00;
        s_addr = 8'h00;
        repeat (20) @(posedge clock_i);
        reset_n_i <= 1'b1;
        t_regs;
        t_tx;
        t_rx;
        t_match;
        t_header;
        t_errors;
        t_addr_phase;
        t_disable;
        t_busy;
        complete_run;
    end
endmodule : tb
`default_nettype wire
